// *** rtl/head_drv_defs.svh ***
/*
  Register offsets, field positions, reset values and timing counts of the print-head driver.
  Assumes inclusion by bare name from the design files; holds definitions only.
*/
`ifndef HEAD_DRV_DEFS_SVH
`define HEAD_DRV_DEFS_SVH

// ---------------------------------------------------------------------------
// Register offsets (byte addresses, low eight address bits)
// ---------------------------------------------------------------------------
`define REG_CTRL        8'h00
`define REG_FEED        8'h04
`define REG_STATUS      8'h08
`define REG_LATCH_LO    8'h0C
`define REG_LATCH_HI    8'h10
`define REG_SHIFT_LO    8'h14
`define REG_SHIFT_HI    8'h18

// ---------------------------------------------------------------------------
// Fields and reset values
// ---------------------------------------------------------------------------
`define CTRL_SW_MODE    0
`define CTRL_SW_SELECT  1
`define CTRL_WIDTH      2
`define CTRL_RESET      2'h0
`define ST_FEED_VALID   0
`define ST_FEED_FULL    1
`define ST_TIMER_ON     2
`define ST_DRIVE_FAULT  3
`define ST_LEVEL_LSB    8

// ---------------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------------
`define HCLK_KHZ        25000
`define INT_CLK_KHZ     800
`define TICK_DIV        (`HCLK_KHZ / `INT_CLK_KHZ)
`define ON_TICKS_DEF    200
`define DISCH_TICKS_DEF 8
`define FEED_DEPTH      32
`define FEED_WIDTH      8

`endif

// *** rtl/head_drv_pkg.sv ***
/*
  Types shared by the print-head driver files.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package head_drv_pkg;

  // ---------------------------------------------------------------------------
  // Pin bundle from the host controller
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic       shift_clk;
    logic       select;
    logic       hold_ctrl_a;
    logic       hold_ctrl_b;
    logic       enable_n;
    logic       reset_n;
    logic [7:0] head_data_in;
  } head_pins_t;

  // ---------------------------------------------------------------------------
  // Protection timer states
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {
    TMR_IDLE  = 4'b0001,
    TMR_ARM   = 4'b0010,
    TMR_ON    = 4'b0100,
    TMR_DISCH = 4'b1000
  } tmr_state_t;

endpackage : head_drv_pkg

// *** rtl/head_line_fifo.sv ***
/*
  Feed FIFO with a registered read stage, parameterised in width and depth.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ns
module head_line_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [WIDTH-1:0]           in_data,
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [WIDTH-1:0]                out_data,
  output logic [$clog2(DEPTH+1):0]        level
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      cnt_ff;
  logic             out_valid_ff;
  logic [WIDTH-1:0] out_data_ff;
  logic             push;
  logic             pop;

  // ---------------------------------------------------------------------------
  // Handshakes
  // ---------------------------------------------------------------------------
  assign in_ready  = cnt_ff != (AW+1)'(DEPTH);
  assign push      = in_valid && in_ready;
  assign pop       = (cnt_ff != '0) && (!out_valid_ff || out_ready);
  assign out_valid = out_valid_ff;
  assign out_data  = out_data_ff;
  assign level     = ($clog2(DEPTH+1)+1)'(cnt_ff) + ($clog2(DEPTH+1)+1)'(out_valid_ff);

  // ---------------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------------
  always_ff @(posedge hclk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr_ff    <= '0;
      rd_ptr_ff    <= '0;
      cnt_ff       <= '0;
      out_valid_ff <= 1'b0;
      out_data_ff  <= '0;
    end else begin
      wr_ptr_ff <= push ? AW'(wr_ptr_ff + 1'b1) : wr_ptr_ff;
      rd_ptr_ff <= pop ? AW'(rd_ptr_ff + 1'b1) : rd_ptr_ff;
      cnt_ff    <= (AW+1)'(cnt_ff + (AW+1)'(push) - (AW+1)'(pop));
      if (pop) begin
        out_data_ff  <= mem_ff[rd_ptr_ff];
        out_valid_ff <= 1'b1;
      end else if (out_ready) begin
        out_valid_ff <= 1'b0;
      end
    end
  end

endmodule : head_line_fifo

// *** rtl/head_shift_driver.sv ***
/*
  64-bit print-head shift register, two latch stages, protection timer and open-drain drive,
  with an AHB-Lite register slave and a software feed path through a FIFO.
  Assumes host pins are asynchronous to hclk and change slower than a few hclk periods.
*/
// Implementation choices: the AHB-Lite interface to the registers and the placing of the registers.
// Functional notes
// - Select high loads eight lanes, low serial
// - Storage is eight by eight, or one by 64
// - 64-bit register advances on host shift clock
// - Data high marks output on, low off
// - Serial output shows last stage bit 63
// - Two latch stages, transparent high, hold low
// - Latch controls act independently of each other
// - Enable high switches all outputs off
// - Reset low clears register and both latches
// - 64 open-drain outputs, sink when on
// - Timer output falls after first internal tick
// - Timer output returns high ending on-period
// - On-period limited to the timer interval
// - Internal timer clock at 800 kHz typical
`timescale 1ns/1ns
`include "head_drv_defs.svh"
module head_shift_driver #(
  parameter int TICK_DIV    = `TICK_DIV,
  parameter int ON_TICKS    = `ON_TICKS_DEF,
  parameter int DISCH_TICKS = `DISCH_TICKS_DEF,
  parameter int FEED_DEPTH  = `FEED_DEPTH
) (
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic                          hreadyout,
  output logic [31:0]                   hrdata,
  output logic                          hresp,
  input  wire head_drv_pkg::head_pins_t head_pins,
  output logic                          serial_out,
  input  wire logic [63:0]              drive_outputs_in,
  output logic [63:0]                   drive_outputs_out,
  output logic [63:0]                   drive_outputs_oe,
  output logic                          protect_timer_out
);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  localparam int TICK_GAP = TICK_DIV;

  head_drv_pkg::head_pins_t pins_s1_ff;
  head_drv_pkg::head_pins_t pins_s2_ff;
  head_drv_pkg::tmr_state_t tmr_state_ff;
  head_drv_pkg::tmr_state_t nxt_tmr_state;

  logic                    shift_clk_s3_ff;
  logic [63:0]             drv_in_s1_ff;
  logic [63:0]             drv_in_s2_ff;
  logic [63:0]             shreg_ff;
  logic [63:0]             nxt_shreg;
  logic [63:0]             par_next;
  logic [63:0]             ser_next;
  logic [63:0]             latch_a_ff;
  logic [63:0]             latch_b_ff;
  logic [63:0]             drive_on_ff;
  logic [7:0]              tick_cnt_ff;
  logic [15:0]             tmr_cnt_ff;
  logic [15:0]             nxt_tmr_cnt;
  logic                    protect_out_ff;
  logic [`CTRL_WIDTH-1:0]  ctrl_ff;
  logic                    wr_pend_ff;
  logic [7:0]              addr_ff;
  logic [31:0]             hrdata_ff;
  logic                    addr_phase;
  logic                    fifo_push;
  logic                    fifo_in_ready;
  logic                    fifo_out_valid;
  logic                    fifo_out_ready;
  logic [7:0]              fifo_out_data;
  logic [$clog2(FEED_DEPTH+1):0] fifo_level;
  logic                    sw_mode;
  logic                    shift_rise;
  logic                    load_step;
  logic                    load_par;
  logic [7:0]              load_data;
  logic                    head_clear;
  logic                    enable_on;
  logic                    demand;
  logic                    tick;
  logic                    drive_fault;
  logic [31:0]             status_word;
  logic [31:0]             rd_mux;

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pins_s1_ff      <= '0;
      pins_s2_ff      <= '0;
      shift_clk_s3_ff <= 1'b0;
      drv_in_s1_ff    <= '0;
      drv_in_s2_ff    <= '0;
    end else begin
      pins_s1_ff      <= head_pins;
      pins_s2_ff      <= pins_s1_ff;
      shift_clk_s3_ff <= pins_s2_ff.shift_clk;
      drv_in_s1_ff    <= drive_outputs_in;
      drv_in_s2_ff    <= drv_in_s1_ff;
    end
  end

  // ---------------------------------------------------------------------------
  // Load source selection
  // ---------------------------------------------------------------------------
  // Software feed takes over the shift data path; latching, enable and head reset still come from the pins.
  assign sw_mode    = ctrl_ff[`CTRL_SW_MODE];
  assign shift_rise = pins_s2_ff.shift_clk && !shift_clk_s3_ff;
  assign fifo_out_ready = sw_mode;
  assign load_step  = sw_mode ? (fifo_out_valid && fifo_out_ready) : shift_rise;
  assign load_par   = sw_mode ? ctrl_ff[`CTRL_SW_SELECT] : pins_s2_ff.select;
  assign load_data  = sw_mode ? fifo_out_data : pins_s2_ff.head_data_in;
  assign head_clear = !pins_s2_ff.reset_n;
  assign enable_on  = !pins_s2_ff.enable_n;

  // ---------------------------------------------------------------------------
  // Shift register
  // ---------------------------------------------------------------------------
  for (genvar lane = 0; lane < 8; lane++) begin : g_lane
    assign par_next[8*lane +: 8] = {shreg_ff[8*lane +: 7], load_data[lane]};
  end
  assign ser_next  = {shreg_ff[62:0], load_data[0]};
  assign nxt_shreg = load_par ? par_next : ser_next;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shreg_ff <= '0;
    end else if (head_clear) begin
      shreg_ff <= '0;
    end else if (load_step) begin
      shreg_ff <= nxt_shreg;
    end
  end

  assign serial_out = shreg_ff[63];

  // ---------------------------------------------------------------------------
  // Latch stages
  // ---------------------------------------------------------------------------
  // Each stage follows its source one hclk late while open; this keeps the path glitch free.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latch_a_ff <= '0;
      latch_b_ff <= '0;
    end else if (head_clear) begin
      latch_a_ff <= '0;
      latch_b_ff <= '0;
    end else begin
      latch_a_ff <= pins_s2_ff.hold_ctrl_a ? shreg_ff : latch_a_ff;
      latch_b_ff <= pins_s2_ff.hold_ctrl_b ? latch_a_ff : latch_b_ff;
    end
  end

  // ---------------------------------------------------------------------------
  // Protection timer
  // ---------------------------------------------------------------------------
  assign tick   = tick_cnt_ff == 8'(TICK_DIV - 1);
  assign demand = (|latch_b_ff) && enable_on;

  always_comb begin
    nxt_tmr_state = tmr_state_ff;
    nxt_tmr_cnt   = tmr_cnt_ff;
    case (tmr_state_ff)
      head_drv_pkg::TMR_IDLE: begin
        if (demand) begin
          nxt_tmr_state = head_drv_pkg::TMR_ARM;
        end
      end
      head_drv_pkg::TMR_ARM: begin
        if (!demand) begin
          nxt_tmr_state = head_drv_pkg::TMR_IDLE;
        end else if (tick) begin
          nxt_tmr_state = head_drv_pkg::TMR_ON;
          nxt_tmr_cnt   = '0;
        end
      end
      head_drv_pkg::TMR_ON: begin
        if (!demand) begin
          nxt_tmr_state = head_drv_pkg::TMR_DISCH;
          nxt_tmr_cnt   = '0;
        end else if (tick && tmr_cnt_ff == 16'(ON_TICKS - 1)) begin
          nxt_tmr_state = head_drv_pkg::TMR_DISCH;
          nxt_tmr_cnt   = '0;
        end else if (tick) begin
          nxt_tmr_cnt = 16'(tmr_cnt_ff + 16'h0001);
        end
      end
      head_drv_pkg::TMR_DISCH: begin
        // A stuck-on line waits here until demand drops, so it cannot retrigger at once.
        if (tick && tmr_cnt_ff >= 16'(DISCH_TICKS - 1)) begin
          nxt_tmr_state = demand ? head_drv_pkg::TMR_DISCH : head_drv_pkg::TMR_IDLE;
        end else if (tick) begin
          nxt_tmr_cnt = 16'(tmr_cnt_ff + 16'h0001);
        end
      end
      default: begin
        nxt_tmr_state = head_drv_pkg::TMR_IDLE;
        nxt_tmr_cnt   = '0;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_ff    <= '0;
      tmr_state_ff   <= head_drv_pkg::TMR_IDLE;
      tmr_cnt_ff     <= '0;
      protect_out_ff <= 1'b1;
    end else begin
      tick_cnt_ff    <= tick ? 8'h00 : 8'(tick_cnt_ff + 8'h01);
      tmr_state_ff   <= nxt_tmr_state;
      tmr_cnt_ff     <= nxt_tmr_cnt;
      protect_out_ff <= nxt_tmr_state != head_drv_pkg::TMR_ON;
    end
  end

  assign protect_timer_out = protect_out_ff;

  // ---------------------------------------------------------------------------
  // Open-drain drive
  // ---------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drive_on_ff <= '0;
    end else begin
      drive_on_ff <= latch_b_ff & {64{enable_on && tmr_state_ff == head_drv_pkg::TMR_ON}};
    end
  end

  assign drive_outputs_out = '0;
  assign drive_outputs_oe  = drive_on_ff;
  assign drive_fault       = |(drive_on_ff & drv_in_s2_ff);

  // ---------------------------------------------------------------------------
  // Feed FIFO
  // ---------------------------------------------------------------------------
  head_line_fifo #(
    .WIDTH (`FEED_WIDTH),
    .DEPTH (FEED_DEPTH)
  ) u_feed (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   (hwdata[7:0]),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data),
    .level     (fifo_level)
  );

  // ---------------------------------------------------------------------------
  // AHB-Lite slave
  // ---------------------------------------------------------------------------
  // Only whole-word transfers are expected, so hsize is not decoded.
  assign addr_phase  = hsel && htrans[1] && hready;
  assign fifo_push   = wr_pend_ff && addr_ff == `REG_FEED;
  assign hreadyout   = !(fifo_push && !fifo_in_ready);
  assign hresp       = 1'b0;
  assign hrdata      = hrdata_ff;
  assign status_word = {16'h0000, 8'(fifo_level), 4'h0, drive_fault,
                        !protect_out_ff, !fifo_in_ready, fifo_out_valid};
  assign rd_mux = (haddr[7:0] == `REG_CTRL)     ? {30'h0, ctrl_ff} :
                  (haddr[7:0] == `REG_STATUS)   ? status_word :
                  (haddr[7:0] == `REG_LATCH_LO) ? latch_b_ff[31:0] :
                  (haddr[7:0] == `REG_LATCH_HI) ? latch_b_ff[63:32] :
                  (haddr[7:0] == `REG_SHIFT_LO) ? shreg_ff[31:0] :
                  (haddr[7:0] == `REG_SHIFT_HI) ? shreg_ff[63:32] : 32'h00000000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      addr_ff    <= 8'h00;
      hrdata_ff  <= 32'h00000000;
    end else if (hreadyout) begin
      wr_pend_ff <= addr_phase && hwrite;
      addr_ff    <= haddr[7:0];
      hrdata_ff  <= (addr_phase && !hwrite) ? rd_mux : 32'h00000000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= `CTRL_RESET;
    end else if (wr_pend_ff && addr_ff == `REG_CTRL) begin
      ctrl_ff <= hwdata[`CTRL_WIDTH-1:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_serial_tail: assert property (
    load_step && !head_clear |=> serial_out == $past(nxt_shreg[63]))
    else $error("Serial output does not follow bit 63.");

  a_lane_load: assert property (
    load_step && load_par && !head_clear |=> shreg_ff[0] == $past(load_data[0]) &&
      shreg_ff[56] == $past(load_data[7]) && shreg_ff[8] == $past(load_data[1]))
    else $error("Parallel lanes did not take their data bits.");

  a_chain_load: assert property (
    load_step && !load_par && !head_clear |=> shreg_ff[8] == $past(shreg_ff[7]) &&
      shreg_ff[0] == $past(load_data[0]))
    else $error("Serial chain did not advance by one stage.");

  a_shift_idle: assert property (
    !load_step && !head_clear |=> $stable(shreg_ff))
    else $error("Shift register moved without a shift edge.");

  a_latch_hold: assert property (
    !pins_s2_ff.hold_ctrl_a && !head_clear |=> $stable(latch_a_ff))
    else $error("First latch changed while closed.");

  a_latch_pass: assert property (
    pins_s2_ff.hold_ctrl_b && !pins_s2_ff.hold_ctrl_a && !head_clear ##1
      pins_s2_ff.hold_ctrl_b && !head_clear |=> latch_b_ff == $past(latch_a_ff, 2))
    else $error("Second latch did not pass the first stage.");

  a_head_clear: assert property (
    head_clear |=> shreg_ff == '0 && latch_a_ff == '0 && latch_b_ff == '0)
    else $error("Head reset left stored data.");

  a_drive_gate: assert property (
    drive_outputs_oe != '0 |-> $past(enable_on) && $past(tmr_state_ff) == head_drv_pkg::TMR_ON &&
      (drive_outputs_oe & ~$past(latch_b_ff)) == '0)
    else $error("Output driven without latch bit, enable or timer.");

  a_timer_start: assert property (
    tmr_state_ff == head_drv_pkg::TMR_ARM && tick && demand |=> !protect_timer_out)
    else $error("Timer output did not fall on the first tick.");

  a_timer_limit: assert property (
    tmr_state_ff == head_drv_pkg::TMR_ON && tick && tmr_cnt_ff == 16'(ON_TICKS - 1)
      |=> protect_timer_out ##1 drive_outputs_oe == '0)
    else $error("On-period ran past its limit.");

  a_tick_rate: assert property (
    tick |-> ##[TICK_GAP:TICK_GAP] tick)
    else $error("Internal tick period is wrong.");

  a_feed_stall: assert property (
    !hreadyout |-> fifo_push && fifo_level == ($clog2(FEED_DEPTH+1)+1)'(FEED_DEPTH + 1))
    else $error("Bus stalled while the feed buffer had space.");

  c_par_load: cover property (load_step && load_par);
  c_ser_load: cover property (load_step && !load_par);
  c_timer_end: cover property (tmr_state_ff == head_drv_pkg::TMR_ON ##1 tmr_state_ff == head_drv_pkg::TMR_DISCH);
  c_feed_stall: cover property (!hreadyout);

endmodule : head_shift_driver

// *** dv/head_host_model.sv ***
/*
  Behavioural host controller for the print-head driver: shift clock, lane data, latch controls,
  select, enable and reset pins.
  Assumes the caller enters each task just after a rising edge of hclk.
*/
`timescale 1ns/1ns
module head_host_model (
  input  wire logic                hclk,
  output head_drv_pkg::head_pins_t pins
);
  // ---------------------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------------------
  initial begin
    pins = 14'h0000;
    pins.enable_n = 1'b1;
    pins.reset_n  = 1'b1;
  end

  // Data is held well past the shift edge because the device samples it through synchronisers.
  task automatic shift_byte(input logic [7:0] d);
    pins.head_data_in <= d;
    repeat (4) @(posedge hclk);
    pins.shift_clk <= 1'b1;
    repeat (4) @(posedge hclk);
    pins.shift_clk <= 1'b0;
    repeat (4) @(posedge hclk);
    pins.head_data_in <= ~d;
    @(posedge hclk);
  endtask : shift_byte

  task automatic set_lines(input logic sel, input logic a, input logic b, input logic en_n, input logic rst_n);
    pins.select      <= sel;
    pins.hold_ctrl_a <= a;
    pins.hold_ctrl_b <= b;
    pins.enable_n    <= en_n;
    pins.reset_n     <= rst_n;
  endtask : set_lines
endmodule : head_host_model

// *** dv/print_head_shift_latch_driver_tb_top.sv ***
/*
  Self-checking bench for the print-head driver: pin loading, latches, protection timer, feed FIFO.
  Assumes the driver top, its package and the host model are compiled first.
*/
`timescale 1ns/1ns
`include "head_drv_defs.svh"
module print_head_shift_latch_driver_tb_top;
  localparam int TD  = 4;
  localparam int ONT = 5;
  logic                     hclk;
  logic                     hresetn;
  logic                     hsel;
  logic [31:0]              haddr;
  logic [1:0]               htrans;
  logic                     hwrite;
  logic [2:0]               hsize;
  logic [31:0]              hwdata;
  logic                     hreadyout;
  logic [31:0]              hrdata;
  logic                     hresp;
  logic                     serial_out;
  logic [63:0]              drive_outputs_out;
  logic [63:0]              drive_outputs_oe;
  logic                     protect_timer_out;
  logic [63:0]              exp_sh;
  logic [63:0]              v;
  logic [31:0]              rd;
  logic [7:0]               d;
  int                       miscompares;
  int                       checks_done;
  int                       n;
  head_drv_pkg::head_pins_t pins;
  // Open-drain pads with pull-ups: a pad reads low only while its output sinks.
  wire  [63:0]              pad_level = ~drive_outputs_oe | drive_outputs_out;

  head_host_model i_host (.hclk(hclk), .pins(pins));
  head_shift_driver #(.TICK_DIV(TD), .ON_TICKS(ONT), .DISCH_TICKS(2), .FEED_DEPTH(32)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .head_pins(pins), .serial_out(serial_out), .drive_outputs_in(pad_level),
    .drive_outputs_out(drive_outputs_out), .drive_outputs_oe(drive_outputs_oe),
    .protect_timer_out(protect_timer_out));

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  function automatic logic [63:0] shift_once(input logic [63:0] s, input logic sel, input logic [7:0] dd);
    logic [63:0] r;
    r = {s[62:0], dd[0]};
    if (sel) for (int k = 0; k < 8; k++) r[8*k +: 8] = {s[8*k +: 7], dd[k]};
    return r;
  endfunction : shift_once

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] q);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask : ahb

  task automatic rd64(input logic [7:0] a, output logic [63:0] q);
    logic [31:0] lo;
    logic [31:0] hi;
    ahb(1'b0, a, 32'h0, lo);
    ahb(1'b0, a + 8'h04, 32'h0, hi);
    q = {hi, lo};
  endtask : rd64

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (20000) @(posedge hclk);
    miscompares++;
    complete_run();
  end

  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  initial begin
    {hresetn, hsel, hwrite, haddr, htrans, hwdata} = '0;
    hsize = 3'h2;
    miscompares = 0;
    checks_done = 0;
    void'($urandom(91976));
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b1, 8'h40, 32'hFFFFFFFF, rd);
    ahb(1'b1, `REG_STATUS, 32'hFFFFFFFF, rd);
    ahb(1'b0, 8'h40, 32'h0, rd);
    chk("unmapped read", 64'h0, {32'h0, rd});
    ahb(1'b0, `REG_STATUS, 32'h0, rd);
    chk("status after reset", 64'h0, {32'h0, rd});
    chk("idle pins", 64'h2, {62'h0, protect_timer_out, hresp});
    $display("test reset done");
    exp_sh = 64'h0;
    for (int i = 0; i < 64; i++) begin
      d = 8'($urandom());
      i_host.shift_byte(d);
      exp_sh = shift_once(exp_sh, 1'b0, d);
      chk("serial out", {63'h0, exp_sh[63]}, {63'h0, serial_out});
    end
    rd64(`REG_SHIFT_LO, v);
    chk("serial chain", exp_sh, v);
    $display("test serial done");
    i_host.set_lines(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 8'h81 : 8'($urandom());
      i_host.shift_byte(d);
      exp_sh = shift_once(exp_sh, 1'b1, d);
    end
    rd64(`REG_SHIFT_LO, v);
    chk("parallel lanes", exp_sh, v);
    i_host.set_lines(1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
    repeat (6) @(posedge hclk);
    rd64(`REG_LATCH_LO, v);
    chk("second stage closed", 64'h0, v);
    i_host.set_lines(1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
    repeat (6) @(posedge hclk);
    i_host.shift_byte(8'h5A);
    rd64(`REG_LATCH_LO, v);
    chk("latched line", exp_sh, v);
    $display("test latch done");
    repeat (40) @(posedge hclk);
    chk("disabled outputs", 64'h0, drive_outputs_oe);
    chk("timer idle", 64'h1, {63'h0, protect_timer_out});
    i_host.set_lines(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    n = 0;
    while (protect_timer_out !== 1'b0 && n < 40) begin
      @(posedge hclk);
      n++;
    end
    chk("timer start", 64'h1, {63'h0, n < 3 + 2 * TD});
    repeat (3) @(posedge hclk);
    chk("outputs on", exp_sh, drive_outputs_oe);
    chk("sink level", 64'h0, drive_outputs_out);
    n = 0;
    while (protect_timer_out === 1'b0 && n < 200) begin
      @(posedge hclk);
      n++;
    end
    chk("on period", 64'h1, {63'h0, n > (ONT - 1) * TD && n <= (ONT + 1) * TD + 2});
    repeat (3) @(posedge hclk);
    chk("stuck on cut", 64'h0, drive_outputs_oe);
    chk("timer ended", 64'h1, {63'h0, protect_timer_out});
    $display("test timer done");
    i_host.set_lines(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
    repeat (6) @(posedge hclk);
    rd64(`REG_SHIFT_LO, v);
    chk("reset shift", 64'h0, v);
    rd64(`REG_LATCH_LO, v);
    chk("reset latch", 64'h0, v);
    chk("reset serial", 64'h0, {63'h0, serial_out});
    i_host.set_lines(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    $display("test pin reset done");
    exp_sh = 64'h0;
    repeat (33) begin
      v[31:0] = $urandom();
      ahb(1'b1, `REG_FEED, v[31:0], rd);
      exp_sh = shift_once(exp_sh, 1'b1, v[7:0]);
    end
    ahb(1'b0, `REG_STATUS, 32'h0, rd);
    chk("feed full", 64'h2103, {32'h0, rd});
    ahb(1'b1, `REG_CTRL, 32'h3, rd);
    ahb(1'b0, `REG_CTRL, 32'h0, rd);
    chk("ctrl readback", 64'h3, {32'h0, rd});
    repeat (40) @(posedge hclk);
    ahb(1'b0, `REG_STATUS, 32'h0, rd);
    chk("feed drained", 64'h0, {32'h0, rd});
    rd64(`REG_SHIFT_LO, v);
    chk("feed lanes", exp_sh, v);
    ahb(1'b1, `REG_CTRL, 32'h0, rd);
    $display("test feed done");
    complete_run();
  end
endmodule : print_head_shift_latch_driver_tb_top
